// >>> verilog/tgc_column_driver.sv
// tft gray column driver data path: capture, two latches, decode, enable chain
`timescale 1ns/100ps
module tgc_column_driver
   import tgc_pkg::*;
(
   input  wire logic          core_clk_i,
   input  wire logic          rstn_i,
   input  wire logic          line_latch_pulse_i,
   input  wire logic          data_shift_clock_i,
   input  wire logic          two_phase_control_i,
   input  wire logic          shift_direction_select_i,
   input  wire tgc_group_type pixel_lane_inputs_i,
   input  wire logic          enable_chain_a_i,
   output logic               enable_chain_a_o,
   output logic               enable_chain_a_oe_n_o,
   input  wire logic          enable_chain_b_i,
   output logic               enable_chain_b_o,
   output logic               enable_chain_b_oe_n_o,
   output tgc_col_type [TGC_COLS-1:0] column_outputs_o
);
   logic [TGC_PIN_W-1:0]  pins_s1_q;
   logic [TGC_PIN_W-1:0]  pins_s2_q;
   logic [1:0]            prev_q;
   logic                  ll_s;
   logic                  sclk_s;
   logic                  phase_s;
   logic                  dir_s;
   logic                  en_in_low;
   tgc_group_type         pix_s;
   logic                  ll_rise;
   logic                  shift_fall;
   logic                  take;
   tgc_line_type          state_q;
   logic [TGC_ADDR_W-1:0] addr_q;
   logic                  chain_out_q;
   logic                  a_oe_n_q;
   logic                  b_oe_n_q;
   logic                  buf_in_ready;
   logic                  buf_out_valid;
   logic                  drain_ready;
   tgc_entry_type         buf_out;
   tgc_pix_type           lat1_q [TGC_COLS];
   tgc_pix_type           lat2_q [TGC_COLS];
   tgc_col_type [TGC_COLS-1:0] col_q;

   // every pin is foreign to core_clk_i; only the second stage is read
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pins_s1_q <= '0;
         pins_s2_q <= '0;
         prev_q    <= '0;
      end else begin
         pins_s1_q <= {line_latch_pulse_i, data_shift_clock_i, two_phase_control_i,
                       shift_direction_select_i, enable_chain_a_i, enable_chain_b_i,
                       pixel_lane_inputs_i};
         pins_s2_q <= pins_s1_q;
         prev_q    <= pins_s2_q[TGC_PIN_W-1 -: 2];
      end
   end

   assign ll_s       = pins_s2_q[TGC_PIN_W-1];
   assign sclk_s     = pins_s2_q[TGC_PIN_W-2];
   assign phase_s    = pins_s2_q[TGC_PIN_W-3];
   assign dir_s      = pins_s2_q[TGC_PIN_W-4];
   assign pix_s      = pins_s2_q[TGC_LANES*TGC_PIX_W-1:0];
   assign ll_rise    = ll_s && !prev_q[1];
   assign shift_fall = !sclk_s && prev_q[0];
   // the chain pin acting as input is chosen by direction
   assign en_in_low  = dir_s ? !pins_s2_q[TGC_PIN_W-6] : !pins_s2_q[TGC_PIN_W-5];
   // a full buffer drops the edge; the drain only stalls on the copy cycle
   assign take       = shift_fall && (state_q == TGC_FILL) && en_in_low && buf_in_ready;

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= TGC_FILL;
         addr_q  <= TGC_ADDR_RST;
      end else if (ll_rise) begin
         state_q <= TGC_FILL;
         addr_q  <= TGC_ADDR_RST;
      end else begin
         case (state_q)
            TGC_FILL: begin
               if (take) begin
                  addr_q <= TGC_ADDR_W'(addr_q + 1'b1);
                  if (addr_q == TGC_ADDR_LAST) begin
                     state_q <= TGC_FULL;
                  end
               end
            end
            TGC_FULL: begin
               state_q <= TGC_FULL;
            end
            default: begin
               state_q <= TGC_FILL;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         chain_out_q <= TGC_CHAIN_IDLE;
         a_oe_n_q    <= TGC_OE_N_RST;
         b_oe_n_q    <= TGC_OE_N_RST;
      end else begin
         chain_out_q <= (state_q != TGC_FULL);
         a_oe_n_q    <= !dir_s;
         b_oe_n_q    <= dir_s;
      end
   end

   assign enable_chain_a_o      = chain_out_q;
   assign enable_chain_b_o      = chain_out_q;
   assign enable_chain_a_oe_n_o = a_oe_n_q;
   assign enable_chain_b_oe_n_o = b_oe_n_q;

   assign drain_ready = !ll_rise;

   tgc_two_entry_buf #(
      .WIDTH ($bits(tgc_entry_type)),
      .DEPTH (TGC_BUF_DEPTH)
   ) u_buf (
      .core_clk_i  (core_clk_i),
      .rstn_i      (rstn_i),
      .flush_i     (ll_rise),
      .in_valid_i  (take),
      .in_ready_o  (buf_in_ready),
      .in_data_i   ({addr_q, pix_s}),
      .out_valid_o (buf_out_valid),
      .out_ready_i (drain_ready),
      .out_data_o  (buf_out)
   );

   function automatic logic [TGC_IDX_W-1:0] tgc_pos(input logic dir,
                                                     input logic [TGC_ADDR_W-1:0] addr,
                                                     input int lane);
      int base;
      base = TGC_LANES * int'(addr) + lane;
      tgc_pos = dir ? TGC_IDX_W'(TGC_COLS - 1 - base) : TGC_IDX_W'(base);
   endfunction

   always_ff @(posedge core_clk_i) begin
      if (buf_out_valid && drain_ready) begin
         for (int l = 0; l < TGC_LANES; l++) begin
            lat1_q[tgc_pos(dir_s, buf_out.addr, l)] <= buf_out.pix[l];
         end
      end
   end

   generate
      for (genvar c = 0; c < TGC_COLS; c++) begin : g_col
         // cleared on reset so the decode never runs on unknown codes before the first line
         always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               lat2_q[c] <= '0;
            end else if (ll_rise) begin
               lat2_q[c] <= lat1_q[c];
            end
         end
         always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               col_q[c] <= TGC_COL_RST;
            end else begin
               col_q[c].ref_lo <= {1'b0, lat2_q[c][TGC_PIX_W-1 -: TGC_FIELD_W]};
               if (phase_s) begin
                  col_q[c].frac <= TGC_STEP_FULL;
               end else begin
                  col_q[c].frac <= 4'({1'b0, lat2_q[c][TGC_FIELD_W-1:0]} + 4'h1);
               end
            end
         end
      end
   endgenerate

   assign column_outputs_o = col_q;

   sequence s_take;
      take;
   endsequence

   sequence s_last_take;
      take && (addr_q == TGC_ADDR_LAST) && !ll_rise;
   endsequence

   AST_ADDR_STEP: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (s_take and !ll_rise) |=> addr_q == TGC_ADDR_W'($past(addr_q) + 1'b1))
      else $error("address did not advance after a capture");

   AST_FULL_AFTER_LAST: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      s_last_take |=> state_q == TGC_FULL)
      else $error("line not full after last group");

   AST_CHAIN_LOW: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      s_last_take ##1 !ll_rise |=> !enable_chain_a_o && !enable_chain_b_o)
      else $error("chain output not low after full line");

   AST_IGNORE_FULL: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      state_q == TGC_FULL && !ll_rise |-> !take ##1 $stable(addr_q))
      else $error("full line accepted more data");

   AST_NEED_ENABLE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !en_in_low |-> !take)
      else $error("data taken without chain enable");

   AST_DIR_ROLES: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      dir_s |=> !enable_chain_a_oe_n_o && enable_chain_b_oe_n_o)
      else $error("chain pin roles wrong for direction");

   AST_DIR_ROLES_ASC: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !dir_s |=> enable_chain_a_oe_n_o && !enable_chain_b_oe_n_o)
      else $error("chain pin roles wrong for ascending direction");

   AST_REARM: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ll_rise |=> state_q == TGC_FILL && addr_q == TGC_ADDR_RST ##1 enable_chain_a_o)
      else $error("line latch did not rearm");

   AST_LATCH_COPY: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ll_rise |=> lat2_q[0] == $past(lat1_q[0]))
      else $error("second latch did not take first latch");

   AST_PHASE_ONE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      phase_s |=> column_outputs_o[0].frac == TGC_STEP_FULL)
      else $error("first phase not at upper reference");

   AST_PHASE_TWO: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !phase_s |=> column_outputs_o[0].frac == 4'({1'b0, $past(lat2_q[0][2:0])} + 4'h1)
                   && column_outputs_o[0].ref_lo == {1'b0, $past(lat2_q[0][5:3])})
      else $error("second phase level wrong");
endmodule

// >>> verilog/tgc_pkg.sv
// shared constants and types of the tft gray column driver data path
package tgc_pkg;
   localparam int TGC_COLS      = 192;
   localparam int TGC_PIX_W     = 6;
   localparam int TGC_FIELD_W   = 3;
   localparam int TGC_LANES     = 3;
   localparam int TGC_GROUPS    = TGC_COLS / TGC_LANES;
   localparam int TGC_ADDR_W    = 6;
   localparam int TGC_IDX_W     = 8;
   localparam int TGC_BUF_DEPTH = 2;
   localparam int TGC_PIN_W     = 6 + TGC_LANES * TGC_PIX_W;

   localparam logic [TGC_ADDR_W-1:0] TGC_ADDR_RST  = 6'h00;
   localparam logic [TGC_ADDR_W-1:0] TGC_ADDR_LAST = 6'h3F;
   localparam logic [3:0]            TGC_STEP_FULL = 4'h8;
   localparam logic                  TGC_CHAIN_IDLE = 1'b1;
   localparam logic                  TGC_OE_N_RST  = 1'b1;

   typedef logic [TGC_PIX_W-1:0] tgc_pix_type;
   typedef tgc_pix_type [TGC_LANES-1:0] tgc_group_type;

   typedef struct packed {
      logic [TGC_ADDR_W-1:0] addr;
      tgc_group_type         pix;
   } tgc_entry_type;

   // output level = V(ref_lo) + frac/8 * (V(ref_lo+1) - V(ref_lo))
   typedef struct packed {
      logic [3:0] ref_lo;
      logic [3:0] frac;
   } tgc_col_type;

   localparam tgc_col_type TGC_COL_RST = 8'h00;

   typedef enum logic [1:0] {
      TGC_FILL = 2'b01,
      TGC_FULL = 2'b10
   } tgc_line_type;
endpackage

// >>> verilog/tgc_two_entry_buf.sv
// small fifo between pixel capture and first-stage latch write
`timescale 1ns/100ps
module tgc_two_entry_buf #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 2
) (
   input  wire logic             core_clk_i,
   input  wire logic             rstn_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_q;
   logic [PTR_W-1:0] rd_q;
   logic [CNT_W-1:0] cnt_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_q != CNT_FULL);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (flush_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == PTR_LAST) ? '0 : PTR_W'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= (rd_q == PTR_LAST) ? '0 : PTR_W'(rd_q + 1'b1);
         end
         cnt_q <= CNT_W'(cnt_q + CNT_W'(push) - CNT_W'(pop));
      end
   end
endmodule

// >>> sim/tgc_ctrl_model.sv
// timing controller model that feeds the column driver
`timescale 1ns/100ps
module tgc_ctrl_model
   import tgc_pkg::*;
(
   input  wire logic    core_clk_i,
   output logic          line_latch_pulse_o,
   output logic          data_shift_clock_o,
   output tgc_group_type pixel_lane_o,
   output logic          chain_en_n_o
);
   initial begin
      line_latch_pulse_o = 1'b0;
      data_shift_clock_o = 1'b0;
      pixel_lane_o = '0;
      chain_en_n_o = 1'b1;
   end
   task automatic wait_edges(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic send_group(input tgc_group_type grp, input int gap);
      pixel_lane_o = grp;
      data_shift_clock_o = 1'b1;
      wait_edges(4);
      data_shift_clock_o = 1'b0;
      wait_edges(4);
      // released lanes invert so a late capture cannot match
      pixel_lane_o = ~grp;
      wait_edges(gap);
   endtask
   task automatic set_enable(input logic en_n);
      chain_en_n_o = en_n;
      wait_edges(4);
   endtask
   task automatic latch_line();
      line_latch_pulse_o = 1'b1;
      wait_edges(4);
      line_latch_pulse_o = 1'b0;
      wait_edges(4);
   endtask
endmodule

// >>> sim/tgc_column_driver_tb.sv
// self-checking bench for the column driver data path
`timescale 1ns/100ps
module tgc_column_driver_tb
   import tgc_pkg::*;
   ;
   typedef struct {
      logic       dir;
      logic       phase;
      logic [5:0] seed;
      logic       extra;
   } tgc_row_type;
   logic                        core_clk, rstn, phase, dir, ll, sc, en_n;
   logic                        a_i, a_o, a_oe_n, b_i, b_o, b_oe_n;
   tgc_group_type               pix;
   tgc_col_type [TGC_COLS-1:0]  cols;
   int                          err_total, checks_done;
   tgc_row_type                 rows [4] = '{'{0, 0, 6'h00, 0}, '{1, 0, 6'h15, 1},
                                             '{0, 1, 6'h2A, 0}, '{1, 1, 6'h07, 0}};
   // device-driven pin wins, else the controller level
   assign a_i = a_oe_n ? en_n : a_o;
   assign b_i = b_oe_n ? en_n : b_o;
   tgc_ctrl_model i_ctrl (.core_clk_i(core_clk), .line_latch_pulse_o(ll), .data_shift_clock_o(sc),
      .pixel_lane_o(pix), .chain_en_n_o(en_n));
   tgc_column_driver i_dut (.core_clk_i(core_clk), .rstn_i(rstn), .line_latch_pulse_i(ll),
      .data_shift_clock_i(sc), .two_phase_control_i(phase), .shift_direction_select_i(dir),
      .pixel_lane_inputs_i(pix), .enable_chain_a_i(a_i), .enable_chain_a_o(a_o),
      .enable_chain_a_oe_n_o(a_oe_n), .enable_chain_b_i(b_i), .enable_chain_b_o(b_o),
      .enable_chain_b_oe_n_o(b_oe_n), .column_outputs_o(cols));
   function automatic tgc_col_type exp_col(input int c, input logic [5:0] s);
      logic [5:0] code;
      code = dir ? 6'(s + 191 - c) : 6'(s + c);
      exp_col.ref_lo = {1'b0, code[5:3]};
      exp_col.frac = phase ? TGC_STEP_FULL : {1'b0, code[2:0]} + 4'h1;
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp_bit(input string nm, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic cmp_col(input int c, input tgc_col_type exp);
      checks_done++;
      if (cols[c] !== exp) begin
         err_total++;
         $display("MISMATCH column %0d expected %h seen %h", c, exp, cols[c]);
      end
   endtask
   task automatic check_line(input logic [5:0] s);
      for (int c = 0; c < TGC_COLS; c++)
         cmp_col(c, exp_col(c, s));
   endtask
   task automatic fill_line(input logic [5:0] s, input logic extra);
      tgc_group_type g;
      i_ctrl.set_enable(1'b0);
      for (int k = 0; k < TGC_GROUPS; k++) begin
         for (int l = 0; l < TGC_LANES; l++)
            g[l] = 6'(s + 3 * k + l);
         // uneven spacing exercises slow controller pacing
         i_ctrl.send_group(g, k % 3);
      end
      i_ctrl.wait_edges(6);
      cmp_bit("chain out", 1'b0, dir ? a_o : b_o);
      cmp_bit("out oe_n", 1'b0, dir ? a_oe_n : b_oe_n);
      cmp_bit("in oe_n", 1'b1, dir ? b_oe_n : a_oe_n);
      if (extra)
         i_ctrl.send_group({3{6'h2A}}, 0);
      i_ctrl.latch_line();
      cmp_bit("chain rearmed", 1'b1, dir ? a_o : b_o);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      summarize();
   end
   initial begin
      err_total = 0;
      checks_done = 0;
      rstn = 1'b0;
      phase = 1'b0;
      dir = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      cmp_bit("a oe_n in reset", 1'b1, a_oe_n);
      cmp_col(0, TGC_COL_RST);
      rstn = 1'b1;
      i_ctrl.wait_edges(4);
      cmp_bit("a oe_n", 1'b1, a_oe_n);
      cmp_bit("b oe_n", 1'b0, b_oe_n);
      foreach (rows[i]) begin
         dir = rows[i].dir;
         phase = rows[i].phase;
         i_ctrl.wait_edges(4);
         fill_line(rows[i].seed, rows[i].extra);
         check_line(rows[i].seed);
      end
      phase = ~phase;
      i_ctrl.wait_edges(5);
      check_line(rows[3].seed);
      // chain input high: groups dropped, first latch keeps the last line
      i_ctrl.set_enable(1'b1);
      i_ctrl.send_group({3{6'h11}}, 0);
      i_ctrl.latch_line();
      check_line(rows[3].seed);
      summarize();
   end
endmodule
